// file: rtl/pcr_top.sv
// PWM clock, reload and offset configuration block with Avalon-MM slave
`timescale 1ns/1ps
`include "pcr_consts.svh"
module pcr_top #(
	parameter int ADDR_W = 4,
	parameter int DATA_W = 32
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic [ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [DATA_W-1:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [DATA_W-1:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic fast_internal_osc_in,
	input wire logic slow_internal_osc_in,
	input wire logic sleep_in,
	input wire logic period_event_in,
	input wire logic [1:0] pwm_mode_in,
	input wire logic counting_up_in,
	input wire logic first_module_load_event_in,
	input wire logic second_module_load_event_in,
	input wire logic first_module_stagger_hit_in,
	input wire logic second_module_stagger_hit_in,
	output logic prescaled_tick_out,
	output pcr_pkg::pcr_clk_cfg_t clk_cfg_out,
	output pcr_pkg::pcr_stagger_cfg_t stagger_cfg_out,
	output logic stagger_trigger_out,
	output logic stagger_dir_effective_out,
	output logic load_event_out,
	output pcr_pkg::pcr_counts_t active_out,
	output logic irq_out
);
	import pcr_pkg::*;

	initial begin
		if (DATA_W != 32 || ADDR_W < 4) begin
			$error("pcr_top: needs 32-bit data and at least 4 address bits");
		end
	end

	logic [7:0] clkcon_ff;
	logic lda_ff;
	logic ldt_ff;
	logic lds_ff;
	logic [7:0] ofcon_ff;
	pcr_counts_t buf_ff;
	pcr_counts_t act_ff;
	pcr_ld_state_t ld_state_ff;
	pcr_ld_state_t nxt_ld_state;
	logic [7:0] stat_ff;
	logic [7:0] imask_ff;
	logic [1:0] fast_sync_ff;
	logic [1:0] slow_sync_ff;
	logic fast_prev_ff;
	logic slow_prev_ff;
	logic [6:0] presc_ff;
	logic rd_pend_ff;
	logic wr_ack_ff;
	logic [7:0] rdata_ff;
	logic load_now;
	logic sel_trig;
	logic src_tick;
	logic wr_hit;
	logic [7:0] wbyte;
	logic [7:0] rd_mux;
	logic [7:0] ps_mask;
	logic stagger_sel_hit;

	// Write strobe qualified by the low byte lane; it lands on the edge at
	// which the master sees waitrequest low, so a write lands exactly once
	// and only after the master has held address and data for a full cycle
	assign wr_hit = avs_write_in && avs_byteenable_in[0] && wr_ack_ff;
	assign wbyte = avs_writedata_in[7:0];

	// Two-flop synchronisers for the internal oscillators
	// The oscillators are free-running and unrelated to the system clock;
	// only the second stage feeds logic, and its delayed copy gives the
	// rising-edge detect. All stages reset low, the oscillators' idle level.
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fast_sync_ff <= 2'h0;
			slow_sync_ff <= 2'h0;
			fast_prev_ff <= 1'b0;
			slow_prev_ff <= 1'b0;
		end else begin
			fast_sync_ff <= {fast_sync_ff[0], fast_internal_osc_in};
			slow_sync_ff <= {slow_sync_ff[0], slow_internal_osc_in};
			fast_prev_ff <= fast_sync_ff[1];
			slow_prev_ff <= slow_sync_ff[1];
		end
	end

	// Source edge pick; internal oscillators ignore sleep, system clock stops
	// A user who needs counting in sleep must pick an internal oscillator.
	// The reserved source code gives no ticks at all.
	always_comb begin
		case (pcr_src_t'(clkcon_ff[1:0]))
			PCR_SRC_SYS: src_tick = !sleep_in;
			PCR_SRC_FAST: src_tick = fast_sync_ff[1] && !fast_prev_ff;
			PCR_SRC_SLOW: src_tick = slow_sync_ff[1] && !slow_prev_ff;
			default: src_tick = 1'b0;
		endcase
	end

	// Divide by 2^n: tick when the low n counter bits are all ones
	assign ps_mask = 8'((8'h01 << clkcon_ff[6:4]) - 8'h01);

	// Prescaler counter and registered tick
	// The counter is free-running, so the first tick after a change of code
	// may come early; every later tick is spaced by exactly 2^n source edges.
	// Seven bits are enough for the largest divide of 128.
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			presc_ff <= 7'h00;
			prescaled_tick_out <= 1'b0;
		end else begin
			prescaled_tick_out <= 1'b0;
			if (src_tick) begin
				presc_ff <= presc_ff + 7'h01;
				prescaled_tick_out <= (presc_ff & ps_mask[6:0]) == ps_mask[6:0];
			end
		end
	end

	// Clock control register; reserved bits never stored
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			clkcon_ff <= `PCR_CTRL_RESET;
		end else if (wr_hit && avs_address_in[3:0] == `PCR_OFF_CLKCON) begin
			clkcon_ff <= wbyte & `PCR_CLK_MASK;
		end
	end

	// Offset control register
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ofcon_ff <= `PCR_CTRL_RESET;
		end else if (wr_hit && avs_address_in[3:0] == `PCR_OFF_OFCON) begin
			ofcon_ff <= wbyte & `PCR_OF_MASK;
		end
	end

	// Reload control bits: mode and source
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ldt_ff <= 1'b0;
			lds_ff <= 1'b0;
		end else if (wr_hit && avs_address_in[3:0] == `PCR_OFF_LDCON) begin
			ldt_ff <= wbyte[`PCR_LD_LDT_BIT];
			lds_ff <= wbyte[`PCR_LD_LDS_BIT];
		end
	end

	// Chosen sibling load event
	assign sel_trig = lds_ff ? second_module_load_event_in : first_module_load_event_in;

	// Armed bit: software sets or cancels, the load clears
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			lda_ff <= 1'b0;
		end else if (wr_hit && avs_address_in[3:0] == `PCR_OFF_LDCON) begin
			lda_ff <= wbyte[`PCR_LD_LDA_BIT];
		end else if (load_now) begin
			lda_ff <= 1'b0;
		end
	end

	// Reload sequencer; arming seen only from the cycle after it is set
	// Arming written on a period event is only seen from the next cycle, so
	// such a load waits for the following period; a trigger that coincides
	// with a period event likewise loads one period later.
	// Clearing the armed bit in any waiting state cancels the load.
	always_comb begin
		nxt_ld_state = ld_state_ff;
		load_now = 1'b0;
		case (ld_state_ff)
			PCR_LD_IDLE: begin
				if (lda_ff) begin
					nxt_ld_state = ldt_ff ? PCR_LD_WAIT_TRIG : PCR_LD_WAIT_END;
				end
			end
			PCR_LD_WAIT_TRIG: begin
				if (!lda_ff) begin
					nxt_ld_state = PCR_LD_IDLE;
				end else if (sel_trig && period_event_in) begin
					nxt_ld_state = PCR_LD_WAIT_END;
				end else if (sel_trig) begin
					nxt_ld_state = PCR_LD_WAIT_END;
				end
			end
			PCR_LD_WAIT_END: begin
				if (!lda_ff) begin
					nxt_ld_state = PCR_LD_IDLE;
				end else if (period_event_in) begin
					load_now = 1'b1;
					nxt_ld_state = PCR_LD_IDLE;
				end
			end
			default: nxt_ld_state = PCR_LD_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ld_state_ff <= PCR_LD_IDLE;
		end else begin
			ld_state_ff <= nxt_ld_state;
		end
	end

	// Holding buffers; no reset so they survive non-power resets
	// A 16-bit value written as two bytes may be torn in the buffer, but the
	// active copy only ever changes as a whole, so the timer never sees it.
	always_ff @(posedge sys_clk_in) begin
		if (wr_hit) begin
			case (avs_address_in[3:0])
				`PCR_OFF_PHH: buf_ff.angle_shift_value[15:8] <= wbyte;
				`PCR_OFF_PHL: buf_ff.angle_shift_value[7:0] <= wbyte;
				`PCR_OFF_DCH: buf_ff.duty_value[15:8] <= wbyte;
				`PCR_OFF_DCL: buf_ff.duty_value[7:0] <= wbyte;
				`PCR_OFF_PRH: buf_ff.period_value[15:8] <= wbyte;
				`PCR_OFF_PRL: buf_ff.period_value[7:0] <= wbyte;
				`PCR_OFF_OFH: buf_ff.stagger_value[15:8] <= wbyte;
				`PCR_OFF_OFL: buf_ff.stagger_value[7:0] <= wbyte;
				`PCR_OFF_ODO: buf_ff.buffered_output_bit <= wbyte[0];
				default: ;
			endcase
		end
	end

	// Active copy taken all at once at the load event
	always_ff @(posedge sys_clk_in) begin
		if (load_now) begin
			act_ff <= buf_ff;
		end
	end

	// Published load event for siblings
	// Siblings see the load one cycle late; a slave's triggered load then
	// waits for its own next period event anyway.
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			load_event_out <= 1'b0;
		end else begin
			load_event_out <= load_now;
		end
	end

	// Offset trigger routing and direction qualification
	// The selected sibling's hit passes only in the slave run modes.
	// The direction bit qualifies hits only in center mode.
	// Selecting the module's own hit is reserved and left to software.
	assign stagger_sel_hit = ofcon_ff[`PCR_OF_OFS_BIT] ? second_module_stagger_hit_in
		: first_module_stagger_hit_in;

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			stagger_trigger_out <= 1'b0;
			stagger_dir_effective_out <= 1'b0;
			stagger_cfg_out <= '0;
			clk_cfg_out <= '0;
		end else begin
			stagger_trigger_out <= (pcr_run_t'(ofcon_ff[6:5]) != PCR_RUN_INDEP)
				&& stagger_sel_hit;
			stagger_dir_effective_out <= (pwm_mode_in == `PCR_MODE_CENTER)
				? (counting_up_in == ofcon_ff[`PCR_OF_OFO_BIT]) : 1'b1;
			stagger_cfg_out.stagger_run_mode <= pcr_run_t'(ofcon_ff[6:5]);
			stagger_cfg_out.stagger_dir_select <= ofcon_ff[`PCR_OF_OFO_BIT];
			stagger_cfg_out.stagger_source_sel <= ofcon_ff[`PCR_OF_OFS_BIT];
			clk_cfg_out.src <= pcr_src_t'(clkcon_ff[1:0]);
			clk_cfg_out.prescale_select <= clkcon_ff[6:4];
			clk_cfg_out.keep_in_sleep <= clkcon_ff[1:0] == 2'h1 || clkcon_ff[1:0] == 2'h2;
		end
	end

	assign active_out = act_ff;

	// Sticky status: load, trigger seen, offset hit; set wins over clear
	// A write of one clears a bit, but an event in the same cycle sets it
	// again, so no event is lost to a late clear.
	// Bits 7 to 3 stay zero.
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			stat_ff <= 8'h00;
		end else begin
			stat_ff <= (stat_ff & ~((wr_hit && avs_address_in[3:0] == `PCR_OFF_STAT)
				? wbyte : 8'h00)) | {5'h00, stagger_sel_hit, sel_trig, load_now};
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			// Mask register and level interrupt, registered so the pin is clean
			// The interrupt follows a clear or mask change one cycle later
			imask_ff <= 8'h00;
			irq_out <= 1'b0;
		end else begin
			if (wr_hit && avs_address_in[3:0] == `PCR_OFF_IMASK) begin
				imask_ff <= wbyte & `PCR_ST_MASK;
			end
			irq_out <= |(stat_ff & imask_ff);
		end
	end

	// Read mux; unused control bits read zero
	// The state readback lets software see whether a load is still pending.
	always_comb begin
		case (avs_address_in[3:0])
			`PCR_OFF_CLKCON: rd_mux = clkcon_ff;
			`PCR_OFF_LDCON: rd_mux = {lda_ff, ldt_ff, 5'h00, lds_ff};
			`PCR_OFF_OFCON: rd_mux = ofcon_ff;
			`PCR_OFF_PHH: rd_mux = buf_ff.angle_shift_value[15:8];
			`PCR_OFF_PHL: rd_mux = buf_ff.angle_shift_value[7:0];
			`PCR_OFF_DCH: rd_mux = buf_ff.duty_value[15:8];
			`PCR_OFF_DCL: rd_mux = buf_ff.duty_value[7:0];
			`PCR_OFF_PRH: rd_mux = buf_ff.period_value[15:8];
			`PCR_OFF_PRL: rd_mux = buf_ff.period_value[7:0];
			`PCR_OFF_OFH: rd_mux = buf_ff.stagger_value[15:8];
			`PCR_OFF_OFL: rd_mux = buf_ff.stagger_value[7:0];
			`PCR_OFF_STAT: rd_mux = stat_ff;
			`PCR_OFF_IMASK: rd_mux = imask_ff;
			`PCR_OFF_ODO: rd_mux = {7'h00, buf_ff.buffered_output_bit};
			`PCR_OFF_ACTIVE: rd_mux = {6'h00, ld_state_ff};
			default: rd_mux = 8'h00;
		endcase
	end

	// Bus handshake: one wait cycle, answer at the second edge
	// The first edge takes the request and latches read data; waitrequest
	// falls for exactly one cycle, and the second edge is where a write
	// lands and read data is taken. The guard flops stop one long request
	// from being answered twice; the master releases before asking again.
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_pend_ff <= 1'b0;
			wr_ack_ff <= 1'b0;
			rdata_ff <= 8'h00;
			avs_waitrequest_out <= 1'b1;
		end else begin
			rd_pend_ff <= avs_read_in && !rd_pend_ff;
			wr_ack_ff <= avs_write_in && !wr_ack_ff;
			avs_waitrequest_out <= !((avs_read_in && !rd_pend_ff)
				|| (avs_write_in && !wr_ack_ff));
			if (avs_read_in && !rd_pend_ff) begin
				rdata_ff <= rd_mux;
			end
		end
	end

	assign avs_readdata_out = {24'h000000, rdata_ff};
endmodule

// file: common/pcr_consts.svh
// Register offsets, field positions, masks and reset values for the PWM config block
`ifndef PCR_CONSTS_SVH
`define PCR_CONSTS_SVH

`define PCR_OFF_CLKCON 4'h0
`define PCR_OFF_LDCON 4'h1
`define PCR_OFF_OFCON 4'h2
`define PCR_OFF_PHH 4'h3
`define PCR_OFF_PHL 4'h4
`define PCR_OFF_DCH 4'h5
`define PCR_OFF_DCL 4'h6
`define PCR_OFF_PRH 4'h7
`define PCR_OFF_PRL 4'h8
`define PCR_OFF_OFH 4'h9
`define PCR_OFF_OFL 4'hA
`define PCR_OFF_STAT 4'hB
`define PCR_OFF_IMASK 4'hC
`define PCR_OFF_ODO 4'hD
`define PCR_OFF_ACTIVE 4'hE

`define PCR_CLK_CS_LSB 0
`define PCR_CLK_PS_LSB 4
`define PCR_CLK_MASK 8'h73
`define PCR_LD_LDA_BIT 7
`define PCR_LD_LDT_BIT 6
`define PCR_LD_LDS_BIT 0
`define PCR_LD_MASK 8'hC1
`define PCR_OF_OFM_LSB 5
`define PCR_OF_OFO_BIT 4
`define PCR_OF_OFS_BIT 0
`define PCR_OF_MASK 8'h71
`define PCR_CTRL_RESET 8'h00

`define PCR_ST_LOAD 0
`define PCR_ST_TRIG 1
`define PCR_ST_HIT 2
`define PCR_ST_MASK 8'h07

`define PCR_CS_RESERVED 2'h3
`define PCR_MODE_CENTER 2'h3

`endif

// file: common/pcr_pkg.sv
// Types shared by the PWM config block
package pcr_pkg;
	typedef enum logic [1:0] {
		PCR_SRC_SYS = 2'h0,
		PCR_SRC_FAST = 2'h1,
		PCR_SRC_SLOW = 2'h2,
		PCR_SRC_RSVD = 2'h3
	} pcr_src_t;

	typedef enum logic [1:0] {
		PCR_RUN_INDEP = 2'h0,
		PCR_RUN_SLAVE = 2'h1,
		PCR_RUN_ONESHOT = 2'h2,
		PCR_RUN_CONT = 2'h3
	} pcr_run_t;

	// Gray-ordered reload sequencer states
	typedef enum logic [1:0] {
		PCR_LD_IDLE = 2'h0,
		PCR_LD_WAIT_TRIG = 2'h1,
		PCR_LD_WAIT_END = 2'h3
	} pcr_ld_state_t;

	typedef struct packed {
		logic [15:0] angle_shift_value;
		logic [15:0] duty_value;
		logic [15:0] period_value;
		logic [15:0] stagger_value;
		logic buffered_output_bit;
	} pcr_counts_t;

	typedef struct packed {
		pcr_src_t src;
		logic [2:0] prescale_select;
		logic keep_in_sleep;
	} pcr_clk_cfg_t;

	typedef struct packed {
		pcr_run_t stagger_run_mode;
		logic stagger_dir_select;
		logic stagger_source_sel;
	} pcr_stagger_cfg_t;
endpackage

// file: verification/pcr_top_assertions.sv
// Port checks for the PWM config block
`timescale 1ns/1ps
module pcr_top_assertions (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic avs_waitrequest_out,
	input wire logic sleep_in,
	input wire logic period_event_in,
	input wire logic first_module_stagger_hit_in,
	input wire logic second_module_stagger_hit_in,
	input wire logic prescaled_tick_out,
	input wire logic stagger_trigger_out,
	input wire logic load_event_out,
	input wire pcr_pkg::pcr_clk_cfg_t clk_cfg_out,
	input wire pcr_pkg::pcr_stagger_cfg_t stagger_cfg_out
);
	import pcr_pkg::*;
	logic sys_run;
	logic [2:0] psel;
	// One clock domain, reset disables every check
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	// System source awake and the prescale code in force
	assign sys_run = clk_cfg_out.src == PCR_SRC_SYS && !sleep_in;
	assign psel = clk_cfg_out.prescale_select;
	sequence s_sys_sleep;
		(clk_cfg_out.src == PCR_SRC_SYS && sleep_in)[*3];
	endsequence
	sequence s_div2_tick;
		(sys_run && psel == 3'h1)[*3] ##0 prescaled_tick_out;
	endsequence
	sequence s_slave_steady;
		(stagger_cfg_out.stagger_run_mode != PCR_RUN_INDEP && $stable(stagger_cfg_out))[*2];
	endsequence
	a_ack_next: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
		|=> !avs_waitrequest_out) else $error("bus answer late");
	a_ack_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("bus answer too long");
	a_load_period: assert property (load_event_out |-> $past(period_event_in))
		else $error("load away from period end");
	a_sleep_still: assert property (s_sys_sleep |-> !prescaled_tick_out)
		else $error("system tick in sleep");
	a_undivided: assert property ((sys_run && psel == 3'h0)[*3] |-> prescaled_tick_out)
		else $error("undivided tick missing");
	a_half_rate: assert property (s_div2_tick |=> !prescaled_tick_out)
		else $error("divide by two wrong");
	a_keep_flag: assert property (clk_cfg_out.keep_in_sleep ==
		(clk_cfg_out.src inside {PCR_SRC_FAST, PCR_SRC_SLOW})) else $error("sleep keep wrong");
	a_indep_quiet: assert property (
		(stagger_cfg_out.stagger_run_mode == PCR_RUN_INDEP)[*2] |-> !stagger_trigger_out)
		else $error("trigger in independent run");
	a_hit_select: assert property (s_slave_steady |-> stagger_trigger_out ==
		(stagger_cfg_out.stagger_source_sel ? $past(second_module_stagger_hit_in)
		: $past(first_module_stagger_hit_in))) else $error("wrong hit source");
endmodule
bind pcr_top pcr_top_assertions i_pcr_top_assertions (.sys_clk_in, .rst_n_in, .avs_read_in,
	.avs_write_in, .avs_waitrequest_out, .sleep_in, .period_event_in,
	.first_module_stagger_hit_in, .second_module_stagger_hit_in, .prescaled_tick_out,
	.stagger_trigger_out, .load_event_out, .clk_cfg_out, .stagger_cfg_out);

// file: verification/pcr_sibling_model.sv
// Sibling PWM modules, shared timer period match and oscillators
`timescale 1ns/1ps
module pcr_sibling_model (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [3:0] req_in,
	output logic period_out,
	output logic [3:0] ev_out,
	output logic fast_out,
	output logic slow_out
);
	logic [4:0] cnt_ff;
	// Period match every 16 clocks; each sibling emits only its own event
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_ff <= 5'h00;
			period_out <= 1'b0;
			ev_out <= 4'h0;
		end else begin
			cnt_ff <= cnt_ff + 5'h01;
			period_out <= cnt_ff[3:0] == 4'hE;
			ev_out <= req_in;
		end
	end
	// Oscillators as divided taps of the timer
	assign fast_out = cnt_ff[1];
	assign slow_out = cnt_ff[4];
endmodule

// file: verification/tb_pcr_top.sv
// Register-level bench for the PWM config block
`timescale 1ns/1ps
module tb_pcr_top;
	import pcr_pkg::*;
	logic clk, rst_n, rd, wr, wt, slp, per, fo, so, tick, trg, lde, irq, up, dir;
	logic [1:0] mode;
	logic [3:0] adr, be, req, ev;
	logic [31:0] wd, rdd;
	pcr_clk_cfg_t ccfg;
	pcr_stagger_cfg_t scfg;
	pcr_counts_t act;
	int err_total, num_checks, nt, nl, nr;
	pcr_top i_pcr_top (.sys_clk_in(clk), .rst_n_in(rst_n), .avs_address_in(adr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be),
		.avs_readdata_out(rdd), .avs_waitrequest_out(wt), .fast_internal_osc_in(fo),
		.slow_internal_osc_in(so), .sleep_in(slp), .period_event_in(per), .pwm_mode_in(mode),
		.counting_up_in(up), .first_module_load_event_in(ev[0]),
		.second_module_load_event_in(ev[1]), .first_module_stagger_hit_in(ev[2]),
		.second_module_stagger_hit_in(ev[3]), .prescaled_tick_out(tick), .clk_cfg_out(ccfg),
		.stagger_cfg_out(scfg), .stagger_trigger_out(trg), .stagger_dir_effective_out(dir),
		.load_event_out(lde), .active_out(act), .irq_out(irq));
	pcr_sibling_model i_pcr_sibling_model (.clk_in(clk), .rst_n_in(rst_n), .req_in(req),
		.period_out(per), .ev_out(ev), .fast_out(fo), .slow_out(so));
	// Free-running clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Count a comparison and report a mismatch
	task automatic chk(input logic [64:0] g, input logic [64:0] e);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	// One bus access, held until waitrequest is seen low; then two idle
	// edges so that registered effects of a write are visible on return
	task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] v);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= {24'h000000, v};
		@(posedge clk);
		while (wt !== 1'b0) @(posedge clk);
		rd <= 1'b0;
		wr <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task automatic rc(input logic [3:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00);
		chk(rdd, e);
	endtask
	// Count ticks, loads and offset triggers over a span
	task automatic run(input int cyc);
		nt = 0;
		nl = 0;
		nr = 0;
		repeat (cyc) begin
			@(posedge clk);
			nt += int'(tick === 1'b1);
			nl += int'(lde === 1'b1);
			nr += int'(trg === 1'b1);
		end
	endtask
	task automatic pulse(input logic [3:0] r);
		req <= r;
		@(posedge clk);
		req <= 4'h0;
		@(posedge clk);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Cut a hang short
	initial begin
		repeat (6000) @(posedge clk);
		err_total++;
		print_verdict();
	end
	// Reset, then the tests
	initial begin
		rst_n = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		adr = 4'h0;
		wd = 32'h00000000;
		be = 4'h1;
		slp = 1'b0;
		req = 4'h0;
		mode = 2'h3;
		up = 1'b1;
		err_total = 0;
		num_checks = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rc(4'h0, 8'h00);
		rc(4'h1, 8'h00);
		rc(4'h2, 8'h00);
		acc(1'b1, 4'h0, 8'hFF);
		rc(4'h0, 8'h73);
		acc(1'b1, 4'h2, 8'hFF);
		rc(4'h2, 8'h71);
		be <= 4'h0;
		acc(1'b1, 4'h0, 8'h00);
		be <= 4'h1;
		rc(4'h0, 8'h73);
		acc(1'b1, 4'hF, 8'hFF);
		rc(4'hF, 8'h00);
		$display("register map done");
		for (int c = 0; c < 3; c++) begin
			acc(1'b1, 4'h0, 8'(c));
			chk(ccfg.src, c);
			chk(ccfg.keep_in_sleep, c != 0);
		end
		for (int p = 0; p < 8; p++) begin
			acc(1'b1, 4'h0, 8'(p * 16));
			run(4);
			run(128);
			chk(nt, 128 >> p);
		end
		slp <= 1'b1;
		acc(1'b1, 4'h0, 8'h00);
		run(64);
		chk(nt, 0);
		acc(1'b1, 4'h0, 8'h01);
		run(64);
		chk(nt > 8, 1);
		slp <= 1'b0;
		$display("clock done");
		for (int i = 3; i < 11; i++) acc(1'b1, 4'(i), 8'(i));
		acc(1'b1, 4'hD, 8'h01);
		acc(1'b1, 4'h1, 8'h80);
		run(40);
		chk(nl, 1);
		chk(act, {64'h030405060708090A, 1'b1});
		rc(4'h1, 8'h00);
		for (int i = 3; i < 11; i++) acc(1'b1, 4'(i), 8'(i + 16));
		acc(1'b1, 4'hD, 8'h00);
		run(40);
		chk(act, {64'h030405060708090A, 1'b1});
		for (int i = 3; i < 11; i++) rc(4'(i), 8'(i + 16));
		for (int s = 0; s < 2; s++) begin
			acc(1'b1, 4'h1, 8'hC0 | 8'(s));
			run(40);
			chk(nl, 0);
			pulse(4'(2 - s));
			run(40);
			chk(nl, 0);
			pulse(4'(s + 1));
			run(40);
			chk(nl, 1);
		end
		chk(act, {64'h131415161718191A, 1'b0});
		@(posedge clk iff per === 1'b1);
		acc(1'b1, 4'h1, 8'h80);
		acc(1'b1, 4'h1, 8'h00);
		run(40);
		chk(nl, 0);
		$display("reload done");
		acc(1'b1, 4'hB, 8'h07);
		rc(4'hB, 8'h00);
		acc(1'b1, 4'hC, 8'h01);
		acc(1'b1, 4'h1, 8'h80);
		run(40);
		chk(irq, 1);
		acc(1'b1, 4'hC, 8'h00);
		chk(irq, 0);
		acc(1'b1, 4'hC, 8'h01);
		chk(irq, 1);
		acc(1'b1, 4'hB, 8'h01);
		chk(irq, 0);
		$display("interrupt done");
		for (int m = 0; m < 4; m++) begin
			acc(1'b1, 4'h2, 8'(m * 32 + 17));
			chk(scfg, m * 4 + 3);
			pulse(4'h4);
			pulse(4'h8);
			run(4);
			chk(nr, m != 0);
		end
		mode <= 2'h3;
		up <= 1'b0;
		run(2);
		chk(dir, 0);
		up <= 1'b1;
		run(2);
		chk(dir, 1);
		mode <= 2'h0;
		up <= 1'b0;
		run(2);
		chk(dir, 1);
		$display("offset done");
		print_verdict();
	end
endmodule
